/* File: pkg/cpu_decoder_regs.vh */
/*
  Opcode fields, flag positions and reset values of the instruction
  decoder. Assumes 16-bit instruction words, most significant bit first.
*/
`ifndef CPU_DECODER_REGS_VH
`define CPU_DECODER_REGS_VH

// ----------------------------------------------------------------
// Upper nibble of the instruction word
// ----------------------------------------------------------------
`define OPN_MISC 4'h0
`define OPN_FLIP 4'h7
`define OPN_SET 4'h8
`define OPN_CLEAR 4'h9
`define OPN_SKIP_SET 4'ha
`define OPN_SKIP_CLEAR 4'hb
`define OPN_REL 4'hd
`define OPN_LONG 4'he
`define OPN_SECOND 4'hf

// ----------------------------------------------------------------
// Bits 11:8 under upper nibble 0000 (literal group)
// ----------------------------------------------------------------
`define LIT_CTRL 4'h0
`define LIT_BANK 4'h1
`define LIT_SUB 4'h8
`define LIT_OR 4'h9
`define LIT_XOR 4'ha
`define LIT_AND 4'hb
`define LIT_RETLIT 4'hc
`define LIT_MUL 4'hd
`define LIT_LOAD 4'he
`define LIT_ADD 4'hf

// ----------------------------------------------------------------
// Bits 11:8 under upper nibble 1110 (bits 11:9 for the call)
// ----------------------------------------------------------------
`define LONG_CALL 3'h6
`define LONG_PTR 4'he
`define LONG_JUMP 4'hf

// ----------------------------------------------------------------
// Low byte of control words 0000 0000 xxxx xxxx
// ----------------------------------------------------------------
`define CTL_NOP 8'h00
`define CTL_STANDBY 8'h03
`define CTL_KICK 8'h04
`define CTL_PUSH 8'h05
`define CTL_PULL 8'h06
`define CTL_TBL_RD 6'h02
`define CTL_TBL_WR 6'h03
`define CTL_IRET 7'h08
`define CTL_RET 7'h09

// ----------------------------------------------------------------
// Bit operation codes on bit_op_o
// ----------------------------------------------------------------
`define BITOP_NONE 2'h0
`define BITOP_CLEAR 2'h1
`define BITOP_SET 2'h2
`define BITOP_FLIP 2'h3

// ----------------------------------------------------------------
// Status flag positions and reset values
// ----------------------------------------------------------------
`define FLAG_C 0
`define FLAG_DC 1
`define FLAG_Z 2
`define FLAG_OV 3
`define FLAG_N 4
`define FLAGS_ALL 5'h1f
`define FLAGS_ZN 5'h14
`define FLAGS_RST 5'h00
`define WORKING_REG_RST 8'h00
`define BANK_RST 4'h0
`define WDT_FLAG_RST 1'b1
`define PD_FLAG_RST 1'b1

`endif

/* File: sim/dec_chk_assertions.sv */
/*
  Port checker for the decoder.
  Assumes binding to cpu_instruction_decoder by port name.
*/
`timescale 1ns/10ps
module dec_chk #(parameter PC_W = 20) (
  input wire core_clk_i, // Clock
  input wire nrst_i, // Reset, active low
  input wire [15:0] instr_i, // Fetched word
  input wire instr_valid_i, // Word present
  input wire instr_ready_o, // Word taken
  input wire [PC_W-1:0] fetch_addr_o, // Fetch address
  input wire [7:0] working_reg_o, // Working register
  input wire [4:0] status_o, // Flags
  input wire [3:0] bank_select_reg_o, // Bank
  input wire [15:0] product_o, // Product
  input wire watchdog_expired_flag_o, // Watchdog flag
  input wire powerdown_flag_o // Powerdown flag
);
  reg skp_q;
  wire tk = instr_valid_i && instr_ready_o;
  // Word after a bit test may be discarded, so it is not judged
  wire lv = tk && !skp_q;
  wire [7:0] k = instr_i[7:0];
  wire [2:0] c = instr_i[10:8];
  wire fl = c[2] ? (c[1] ? status_o[4] : status_o[3])
    : (c[1] ? status_o[0] : status_o[2]);
  wire br = lv && instr_i[15:11] == 5'b11100;
  wire bt = fl ^ c[0];
  wire [PC_W-1:0] t8 = fetch_addr_o + {{(PC_W-8){k[7]}}, k} + 1'b1;
  wire [PC_W-1:0] t11 = fetch_addr_o
    + {{(PC_W-11){instr_i[10]}}, instr_i[10:0]} + 1'b1;
  always @(posedge core_clk_i or negedge nrst_i)
    if (!nrst_i)
      skp_q <= 1'b0;
    else
      skp_q <= tk ? instr_i[15:13] == 3'h5 : skp_q;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  lit_load_a: assert property (lv && instr_i[15:8] == 8'h0e
    |=> working_reg_o == $past(k) && $stable(status_o)) else $error("load");
  bank_load_a: assert property (lv && instr_i[15:4] == 12'h010
    |=> bank_select_reg_o == $past(instr_i[3:0]) && $stable(status_o))
    else $error("bank load");
  add_result_a: assert property (lv && instr_i[15:8] == 8'h0f
    |=> working_reg_o == 8'($past(working_reg_o) + $past(k))
    && status_o[2] == (working_reg_o == 8'h00)) else $error("add");
  sub_result_a: assert property (lv && instr_i[15:8] == 8'h08
    |=> working_reg_o == 8'($past(k) - $past(working_reg_o))
    && status_o[0] == ($past(k) >= $past(working_reg_o))) else $error("sub");
  logic_flags_a: assert property (lv && instr_i[15:10] == 6'h02
    && instr_i[9:8] != 2'h0 |=> status_o[4] == working_reg_o[7]
    && status_o[2] == (working_reg_o == 8'h00)
    && status_o[1:0] == $past(status_o[1:0])
    && status_o[3] == $past(status_o[3])) else $error("logic flags");
  branch_go_a: assert property (br && bt
    |=> !instr_ready_o && fetch_addr_o == $past(t8) ##1 instr_ready_o)
    else $error("branch taken");
  branch_stay_a: assert property (br && !bt |=> instr_ready_o
    && fetch_addr_o == $past(fetch_addr_o) + 1'b1 && $stable(status_o))
    else $error("branch idle");
  rel_jump_a: assert property (lv && instr_i[15:11] == 5'b11010
    |=> !instr_ready_o && fetch_addr_o == $past(t11) ##1 instr_ready_o)
    else $error("relative jump");
  standby_a: assert property (lv && instr_i == 16'h0003
    |=> watchdog_expired_flag_o && !powerdown_flag_o) else $error("standby");
  kick_a: assert property (lv && instr_i == 16'h0004
    |=> watchdog_expired_flag_o && powerdown_flag_o) else $error("kick");
  mul_result_a: assert property (lv && instr_i[15:8] == 8'h0d
    |=> product_o == $past(working_reg_o) * $past(k) && $stable(status_o))
    else $error("multiply");
  abs_jump_a: assert property (lv && instr_i[15:8] == 8'hef ##1 tk
    |=> fetch_addr_o == {$past(instr_i[11:0]), $past(k, 2)})
    else $error("absolute jump");
  cover property (br && bt);
  cover property (br && !bt);
  cover property (skp_q && tk);
endmodule

/* File: sim/prog_mem.sv */
/*
  Program memory model feeding fetched words.
  Assumes its image is loaded while the decoder is held in reset.
*/
`timescale 1ns/10ps
module prog_mem #(parameter PC_W = 20) (
  input wire [PC_W-1:0] addr_i, // Fetch address
  input wire stall_i, // Answer late this cycle
  input wire [7:0] fdat_i, // File register contents
  output wire [15:0] instr_o, // Word at addr_i
  output wire valid_o, // Word present
  output wire [7:0] file_o // File data
);
  logic [15:0] mem [0:15];
  // Outside the image a self-loop parks the core
  wire [15:0] w = addr_i < 16 ? mem[addr_i[3:0]] : 16'hd7ff;
  // A stalled bus shows garbage, never the word
  assign instr_o = stall_i ? ~w : w;
  assign valid_o = !stall_i;
  assign file_o = fdat_i;
endmodule

/* File: sim/tb.sv */
/*
  Random programs run through the decoder; end state is checked.
  Assumes prog_mem and dec_chk beside it.
*/
`timescale 1ns/10ps
module tb;
  logic core_clk_i = 0;
  logic nrst_i = 0;
  logic prescaler_assigned_i = 0;
  logic irq_high_active_i = 0;
  logic stall = 0;
  logic [19:0] stack_top_i = 0;
  logic [7:0] fd = 0;
  logic [31:0] rs = 32'hc6dc;
  logic [7:0] opc [0:4] = '{8'h0f, 8'h08, 8'h0b, 8'h09, 8'h0a};
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  wire [15:0] instr_i;
  wire [15:0] product_o;
  wire [19:0] fetch_addr_o;
  wire [7:0] file_data_i;
  wire [7:0] working_reg_o;
  wire [4:0] status_o;
  wire [3:0] bank_select_reg_o;
  wire instr_valid_i;
  wire instr_ready_o;
  wire watchdog_expired_flag_o;
  wire powerdown_flag_o;
  prog_mem i_mem (.addr_i(fetch_addr_o), .stall_i(stall), .fdat_i(fd),
    .instr_o(instr_i), .valid_o(instr_valid_i), .file_o(file_data_i));
  cpu_instruction_decoder i_dut (.*, .product_load_o(), .ptr_load_o(),
    .ptr_sel_o(), .ptr_value_o(), .bit_op_o(), .file_addr_o(),
    .bit_index_o(), .access_bank_o(), .read_pins_o(), .stack_push_o(),
    .prescaler_clear_o(), .stack_data_o(), .stack_pull_o(), .tbl_mode_o(),
    .fast_save_o(), .fast_restore_o(), .global_irq_enable_high_o(),
    .peripheral_irq_enable_low_o(), .tbl_read_o(), .tbl_write_o(),
    .wdt_clear_o(), .standby_o());
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // {N,OV,Z,DC,C} and result; subtract carry means no borrow
  function automatic logic [12:0] alu(input logic [2:0] o,
    input logic [7:0] w, k);
    logic [8:0] s;
    logic [4:0] h;
    logic v;
    s = o == 0 ? w + k : {1'b0, k} - w;
    h = o == 0 ? w[3:0] + k[3:0] : {1'b0, k[3:0]} - w[3:0];
    v = o == 0 ? w[7] == k[7] && s[7] != w[7] : w[7] != k[7] && s[7] != k[7];
    case (o)
      2: s = w & k;
      3: s = w | k;
      4: s = w ^ k;
    endcase
    if (o > 1)
      return {s[7], 1'b0, s[7:0] == 0, 2'b00, s[7:0]};
    return {s[7], v, s[7:0] == 0, h[4] ^ (o == 1), s[8] ^ (o == 1), s[7:0]};
  endfunction
  task chk(input logic [19:0] g, e);
    n_compared++;
    if (g !== e)
      $display("wrong value at %0t: %h not %h", $time, g, e);
    if (g !== e)
      err_count++;
  endtask
  task give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
    forever #2 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    rs <= xs(rs);
    stall <= rs[2:0] == 0;
    prescaler_assigned_i <= rs[5];
    irq_high_active_i <= rs[6];
    stack_top_i <= rs[31:12];
    cyc++;
    if (cyc == 4000)
      err_count++;
    if (cyc == 4000)
      give_verdict;
  end
  initial
  begin
    logic [31:0] r;
    logic [12:0] x;
    logic [7:0] a, b;
    logic [3:0] bk;
    logic [2:0] opi, c, bi;
    logic sk, nap, sp, tn;
    repeat (12) @(posedge core_clk_i);
    for (int t = 0; t < 40; t++)
    begin
      @(posedge core_clk_i) nrst_i <= 0;
      fd <= rs[31:24];
      r = xs(rs);
      {a, b, bk, c, bi, sk, nap} = r[27:0];
      opi = 3'(r[18:16] % 5);
      // Carry, half carry and zero at once; then equal operands
      if (t == 0) {a, b, opi} = {16'hff01, 3'd0};
      if (t == 1) {a, b, opi} = {16'h8080, 3'd1};
      @(negedge core_clk_i);
      i_mem.mem[0] = {8'h0e, a};
      i_mem.mem[1] = {opc[opi], b};
      i_mem.mem[2] = {12'h010, bk};
      i_mem.mem[3] = {sk ? 4'hb : 4'ha, bi, 1'b0, 8'h10};
      i_mem.mem[4] = 16'h0d03;
      i_mem.mem[5] = {5'b11100, c, 8'h01};
      i_mem.mem[6] = 16'h0d05;
      i_mem.mem[7] = nap ? 16'h0003 : 16'h0004;
      i_mem.mem[8] = 16'hef0b;
      i_mem.mem[9] = 16'hf000;
      i_mem.mem[10] = 16'hd7ff;
      i_mem.mem[11] = 16'hd7ff;
      @(posedge core_clk_i) nrst_i <= 1;
      x = alu(opi, a, b);
      sp = sk ? !fd[bi] : fd[bi];
      tn = (c[2] ? (c[1] ? x[12] : x[11]) : (c[1] ? x[8] : x[10])) ^ c[0];
      for (int i = 0; i < 80 && fetch_addr_o !== 20'd11; i++)
        @(posedge core_clk_i);
      repeat (3) @(negedge core_clk_i);
      chk(fetch_addr_o, 20'd11);
      chk(working_reg_o, x[7:0]);
      chk(status_o, x[12:8]);
      chk(bank_select_reg_o, bk);
      chk(product_o, tn ? (sp ? 0 : x[7:0] * 3) : x[7:0] * 5);
      chk({watchdog_expired_flag_o, powerdown_flag_o}, {1'b1, !nap});
      $display("test %0d done", t);
    end
    give_verdict;
  end
endmodule
bind cpu_instruction_decoder dec_chk #(.PC_W(PC_W)) i_chk (.*);

/* File: verilog/branch_unit.v */
/*
  Branch condition test and relative target adder.
  Assumes pc_i is the word address of the branch instruction itself.
*/
`timescale 1ns/10ps
`include "cpu_decoder_regs.vh"

module branch_unit #(
  parameter PC_W = 20
) (
  input wire [2:0] cond_i, // Condition code bits 10:8
  input wire [4:0] flags_i, // Current status flags
  input wire [PC_W-1:0] pc_i, // Address of this word
  input wire [10:0] off_i, // Offset field
  input wire long_i, // Eleven-bit offset instead of eight
  output reg taken_o, // Condition holds
  output reg [PC_W-1:0] target_o // Branch target
);
  reg [10:0] off;
  always @*
  begin
    case (cond_i[2:1])
      2'h0: taken_o = flags_i[`FLAG_Z];
      2'h1: taken_o = flags_i[`FLAG_C];
      2'h2: taken_o = flags_i[`FLAG_OV];
      default: taken_o = flags_i[`FLAG_N];
    endcase
    taken_o = taken_o ^ cond_i[0];
    off = long_i ? off_i : {{3{off_i[7]}}, off_i[7:0]};
    // Word offset from the following instruction
    target_o = pc_i + {{(PC_W-11){1'b0}}, 11'h001} +
               {{(PC_W-11){off[10]}}, off};
  end
endmodule

/* File: verilog/cpu_instruction_decoder.v */
/*
  Instruction decoder and sequencer for the 8-bit core: bit, control,
  literal and table instructions. Assumes a fetcher that presents the
  word at fetch_addr_o with instr_valid_i while instr_ready_o is high,
  and file data for the addressed register on file_data_i in that cycle.
*/
`timescale 1ns/10ps
`include "cpu_decoder_regs.vh"

// Functional notes
// - Bit test skips decode 1011/1010, flags untouched
// - Skip costs one, two or three cycles
// - Conditional branches on zero, carry, negative
// - Overflow branches; taken costs two cycles
// - Program counter changes take two cycles
// - Two-word call, bit s saves fast
// - Two-word absolute jump, twenty address bits
// - Lone 1111 word and zero word idle
// - Stack pull and push, one cycle
// - Returns take two cycles; interrupt return enables
// - Return with literal loads working register
// - Standby and watchdog kick update two flags
// - Literal add updates all five flags
// - Literal subtract computes literal minus working
// - Logic literals update zero and negative only
// - Multiply and load literal, no flags
// - Bank literal loads bank register low nibble
// - Two-word pointer load, twelve-bit literal
// - Table read with four pointer modes
// - Table write with four pointer modes
// - Bit ops one cycle, ports read pins
// - Bit op on timer clears its prescaler
module cpu_instruction_decoder #(
  parameter PC_W = 20,
  parameter [7:0] TIMER_ZERO_ADDR = 8'h00,
  parameter [7:0] PORT_LO = 8'h80,
  parameter [7:0] PORT_HI = 8'h8f
) (
  input wire core_clk_i, // Core clock
  input wire nrst_i, // Asynchronous reset, active low
  input wire [15:0] instr_i, // Fetched word
  input wire instr_valid_i, // Fetched word present
  input wire [7:0] file_data_i, // Addressed file register
  input wire [PC_W-1:0] stack_top_i, // Return stack top
  input wire prescaler_assigned_i, // Prescaler serves the timer
  input wire irq_high_active_i, // Return is from high level
  output reg instr_ready_o, // Word will be taken
  output reg [PC_W-1:0] fetch_addr_o, // Word address to fetch
  output reg [7:0] working_reg_o, // Working register
  output reg [4:0] status_o, // N, OV, Z, DC, C
  output reg [3:0] bank_select_reg_o, // Bank select, low nibble
  output reg [15:0] product_o, // Multiply result
  output reg product_load_o, // Product strobe
  output reg ptr_load_o, // Pointer load strobe
  output reg [1:0] ptr_sel_o, // Pointer number
  output reg [11:0] ptr_value_o, // Pointer value
  output reg [1:0] bit_op_o, // Bit operation strobe
  output reg [7:0] file_addr_o, // File address of bit op
  output reg [2:0] bit_index_o, // Bit index of bit op
  output reg access_bank_o, // Bank bit of bit op
  output reg read_pins_o, // Take pin levels for port
  output reg prescaler_clear_o, // Clear timer prescaler
  output reg stack_push_o, // Push strobe
  output reg [PC_W-1:0] stack_data_o, // Pushed address
  output reg stack_pull_o, // Pull strobe
  output reg fast_save_o, // Save shadow registers
  output reg fast_restore_o, // Restore shadow registers
  output reg global_irq_enable_high_o, // Set high enable
  output reg peripheral_irq_enable_low_o, // Set low enable
  output reg tbl_read_o, // Table read strobe
  output reg tbl_write_o, // Table write strobe
  output reg [1:0] tbl_mode_o, // Pointer mode
  output reg wdt_clear_o, // Watchdog kick strobe
  output reg standby_o, // Standby entry strobe
  output reg watchdog_expired_flag_o, // Watchdog flag
  output reg powerdown_flag_o // Powerdown flag
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [4:0] ST_EXEC = 5'h01;
  localparam [4:0] ST_SECOND = 5'h02;
  localparam [4:0] ST_STALL = 5'h04;
  localparam [4:0] ST_SKIP = 5'h08;
  localparam [4:0] ST_SKIP2 = 5'h10;

  function is_two_word;
    input [15:0] w;
    begin
      is_two_word = (w[15:12] == `OPN_LONG) &&
                    ((w[11:9] == `LONG_CALL) || (w[11:8] == `LONG_PTR) ||
                     (w[11:8] == `LONG_JUMP));
    end
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  reg rst_meta_q;
  reg rst_n_q;
  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  reg [4:0] state_q, state_d;
  reg [15:0] first_q, first_d;
  reg [PC_W-1:0] pc_d;
  reg ready_d;
  reg [7:0] w_d;
  reg [4:0] flags_d;
  reg [3:0] bank_d;
  reg [15:0] prod_d;
  reg prod_ld_d, ptr_ld_d, pre_clr_d, pins_d;
  reg [1:0] ptr_sel_d, bit_op_d, tbl_mode_d;
  reg [11:0] ptr_val_d;
  reg push_d, pull_d, fsave_d, frest_d, gie_h_d, gie_l_d;
  reg [PC_W-1:0] sdata_d;
  reg trd_d, twr_d, kick_d, stby_d, to_d, pd_d;
  wire take = instr_valid_i && instr_ready_o;
  wire [7:0] alu_res;
  wire [4:0] alu_flags, alu_mask;
  wire br_taken;
  wire [PC_W-1:0] br_target;

  lit_alu u_alu (
    .op_i(instr_i[11:8]),
    .w_i(working_reg_o),
    .k_i(instr_i[7:0]),
    .res_o(alu_res),
    .flags_o(alu_flags),
    .mask_o(alu_mask)
  );

  branch_unit #(.PC_W(PC_W)) u_branch (
    .cond_i(instr_i[10:8]),
    .flags_i(status_o),
    .pc_i(fetch_addr_o),
    .off_i(instr_i[10:0]),
    .long_i(instr_i[15:12] == `OPN_REL),
    .taken_o(br_taken),
    .target_o(br_target)
  );

  // ----------------------------------------------------------------
  // Decode and sequencing
  // ----------------------------------------------------------------
  always @*
  begin
    state_d = state_q;
    first_d = first_q;
    pc_d = fetch_addr_o;
    ready_d = 1'b1;
    w_d = working_reg_o;
    flags_d = status_o;
    bank_d = bank_select_reg_o;
    prod_d = product_o;
    prod_ld_d = 1'b0;
    ptr_ld_d = 1'b0;
    ptr_sel_d = ptr_sel_o;
    ptr_val_d = ptr_value_o;
    bit_op_d = `BITOP_NONE;
    pins_d = 1'b0;
    pre_clr_d = 1'b0;
    push_d = 1'b0;
    sdata_d = stack_data_o;
    pull_d = 1'b0;
    fsave_d = 1'b0;
    frest_d = 1'b0;
    gie_h_d = 1'b0;
    gie_l_d = 1'b0;
    trd_d = 1'b0;
    twr_d = 1'b0;
    tbl_mode_d = tbl_mode_o;
    kick_d = 1'b0;
    stby_d = 1'b0;
    to_d = watchdog_expired_flag_o;
    pd_d = powerdown_flag_o;
    if (state_q == ST_STALL)
      state_d = ST_EXEC;
    else if (take)
    begin
      pc_d = fetch_addr_o + {{(PC_W-1){1'b0}}, 1'b1};
      case (state_q)
        ST_SKIP:
          // Skipped first word drags its second word along
          state_d = is_two_word(instr_i) ? ST_SKIP2 : ST_EXEC;
        ST_SKIP2:
          state_d = ST_EXEC;
        ST_SECOND:
        begin
          state_d = ST_EXEC;
          if (first_q[11:8] == `LONG_PTR)
          begin
            ptr_ld_d = 1'b1;
            ptr_sel_d = first_q[5:4];
            ptr_val_d = {first_q[3:0], instr_i[7:0]};
          end
          else
          begin
            // Target leaves no slot to flush: both words are consumed
            pc_d = {instr_i[11:0], first_q[7:0]};
            if (first_q[11:9] == `LONG_CALL)
            begin
              push_d = 1'b1;
              sdata_d = fetch_addr_o + {{(PC_W-1){1'b0}}, 1'b1};
              fsave_d = first_q[8];
            end
          end
        end
        ST_EXEC:
        begin
          case (instr_i[15:12])
            `OPN_SKIP_CLEAR, `OPN_SKIP_SET:
            begin
              if (file_data_i[instr_i[11:9]] ==
                  (instr_i[15:12] == `OPN_SKIP_SET))
                state_d = ST_SKIP;
            end
            `OPN_CLEAR, `OPN_SET, `OPN_FLIP:
            begin
              if (instr_i[15:12] == `OPN_CLEAR)
                bit_op_d = `BITOP_CLEAR;
              else if (instr_i[15:12] == `OPN_SET)
                bit_op_d = `BITOP_SET;
              else
                bit_op_d = `BITOP_FLIP;
              pins_d = (instr_i[7:0] >= PORT_LO) &&
                       (instr_i[7:0] <= PORT_HI);
              pre_clr_d = (instr_i[7:0] == TIMER_ZERO_ADDR) &&
                          prescaler_assigned_i;
            end
            `OPN_REL:
            begin
              pc_d = br_target;
              state_d = ST_STALL;
              ready_d = 1'b0;
              if (instr_i[11])
              begin
                push_d = 1'b1;
                sdata_d = fetch_addr_o + {{(PC_W-1){1'b0}}, 1'b1};
              end
            end
            `OPN_LONG:
            begin
              if (is_two_word(instr_i))
              begin
                state_d = ST_SECOND;
                first_d = instr_i;
              end
              else if (!instr_i[11] && br_taken)
              begin
                pc_d = br_target;
                state_d = ST_STALL;
                ready_d = 1'b0;
              end
            end
            `OPN_MISC:
            begin
              case (instr_i[11:8])
                `LIT_ADD, `LIT_SUB, `LIT_AND, `LIT_OR, `LIT_XOR:
                begin
                  w_d = alu_res;
                  flags_d = (status_o & ~alu_mask) | (alu_flags & alu_mask);
                end
                `LIT_MUL:
                begin
                  prod_d = {8'h00, working_reg_o} *
                           {8'h00, instr_i[7:0]};
                  prod_ld_d = 1'b1;
                end
                `LIT_LOAD:
                  w_d = instr_i[7:0];
                `LIT_RETLIT:
                begin
                  w_d = instr_i[7:0];
                  pull_d = 1'b1;
                  pc_d = stack_top_i;
                  state_d = ST_STALL;
                  ready_d = 1'b0;
                end
                `LIT_BANK:
                  if (instr_i[7:4] == 4'h0)
                    bank_d = instr_i[3:0];
                `LIT_CTRL:
                begin
                  if (instr_i[7:0] == `CTL_STANDBY)
                  begin
                    stby_d = 1'b1;
                    to_d = 1'b1;
                    pd_d = 1'b0;
                  end
                  else if (instr_i[7:0] == `CTL_KICK)
                  begin
                    kick_d = 1'b1;
                    to_d = 1'b1;
                    pd_d = 1'b1;
                  end
                  else if (instr_i[7:0] == `CTL_PUSH)
                  begin
                    push_d = 1'b1;
                    sdata_d = fetch_addr_o + {{(PC_W-1){1'b0}}, 1'b1};
                  end
                  else if (instr_i[7:0] == `CTL_PULL)
                    pull_d = 1'b1;
                  else if (instr_i[7:2] == `CTL_TBL_RD ||
                           instr_i[7:2] == `CTL_TBL_WR)
                  begin
                    trd_d = (instr_i[7:2] == `CTL_TBL_RD);
                    twr_d = (instr_i[7:2] == `CTL_TBL_WR);
                    tbl_mode_d = instr_i[1:0];
                    state_d = ST_STALL;
                    ready_d = 1'b0;
                  end
                  else if (instr_i[7:1] == `CTL_IRET ||
                           instr_i[7:1] == `CTL_RET)
                  begin
                    pull_d = 1'b1;
                    frest_d = instr_i[0];
                    pc_d = stack_top_i;
                    state_d = ST_STALL;
                    ready_d = 1'b0;
                    if (instr_i[7:1] == `CTL_IRET)
                    begin
                      gie_h_d = irq_high_active_i;
                      gie_l_d = !irq_high_active_i;
                    end
                  end
                end
                default:
                  w_d = working_reg_o;
              endcase
            end
            default:
              state_d = ST_EXEC;
          endcase
        end
        default:
          state_d = ST_EXEC;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State and output registers
  // ----------------------------------------------------------------
  always @(posedge core_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= ST_EXEC;
      first_q <= 16'h0000;
      instr_ready_o <= 1'b0;
      fetch_addr_o <= {PC_W{1'b0}};
      working_reg_o <= `WORKING_REG_RST;
      status_o <= `FLAGS_RST;
      bank_select_reg_o <= `BANK_RST;
      product_o <= 16'h0000;
      product_load_o <= 1'b0;
      ptr_load_o <= 1'b0;
      ptr_sel_o <= 2'h0;
      ptr_value_o <= 12'h000;
      bit_op_o <= `BITOP_NONE;
      file_addr_o <= 8'h00;
      bit_index_o <= 3'h0;
      access_bank_o <= 1'b0;
      read_pins_o <= 1'b0;
      prescaler_clear_o <= 1'b0;
      stack_push_o <= 1'b0;
      stack_data_o <= {PC_W{1'b0}};
      stack_pull_o <= 1'b0;
      fast_save_o <= 1'b0;
      fast_restore_o <= 1'b0;
      global_irq_enable_high_o <= 1'b0;
      peripheral_irq_enable_low_o <= 1'b0;
      tbl_read_o <= 1'b0;
      tbl_write_o <= 1'b0;
      tbl_mode_o <= 2'h0;
      wdt_clear_o <= 1'b0;
      standby_o <= 1'b0;
      watchdog_expired_flag_o <= `WDT_FLAG_RST;
      powerdown_flag_o <= `PD_FLAG_RST;
    end
    else
    begin
      state_q <= state_d;
      first_q <= first_d;
      instr_ready_o <= ready_d;
      fetch_addr_o <= pc_d;
      working_reg_o <= w_d;
      status_o <= flags_d;
      bank_select_reg_o <= bank_d;
      product_o <= prod_d;
      product_load_o <= prod_ld_d;
      ptr_load_o <= ptr_ld_d;
      ptr_sel_o <= ptr_sel_d;
      ptr_value_o <= ptr_val_d;
      bit_op_o <= bit_op_d;
      if (take && state_q == ST_EXEC)
      begin
        file_addr_o <= instr_i[7:0];
        bit_index_o <= instr_i[11:9];
        access_bank_o <= instr_i[8];
      end
      read_pins_o <= pins_d;
      prescaler_clear_o <= pre_clr_d;
      stack_push_o <= push_d;
      stack_data_o <= sdata_d;
      stack_pull_o <= pull_d;
      fast_save_o <= fsave_d;
      fast_restore_o <= frest_d;
      global_irq_enable_high_o <= gie_h_d;
      peripheral_irq_enable_low_o <= gie_l_d;
      tbl_read_o <= trd_d;
      tbl_write_o <= twr_d;
      tbl_mode_o <= tbl_mode_d;
      wdt_clear_o <= kick_d;
      standby_o <= stby_d;
      watchdog_expired_flag_o <= to_d;
      powerdown_flag_o <= pd_d;
    end
  end
endmodule

/* File: verilog/lit_alu.v */
/*
  Literal arithmetic and logic on the working register.
  Assumes op_i is bits 11:8 of a literal-group instruction word.
*/
`timescale 1ns/10ps
`include "cpu_decoder_regs.vh"

module lit_alu (
  input wire [3:0] op_i, // Literal operation code
  input wire [7:0] w_i, // Working register value
  input wire [7:0] k_i, // Literal
  output reg [7:0] res_o, // Result
  output reg [4:0] flags_o, // New flag values
  output reg [4:0] mask_o // Flags that this operation writes
);
  reg [7:0] b;
  reg [8:0] sum;
  reg [4:0] lo;
  always @*
  begin
    b = ~w_i;
    sum = 9'h000;
    lo = 5'h00;
    res_o = w_i;
    flags_o = 5'h00;
    mask_o = 5'h00;
    case (op_i)
      `LIT_ADD, `LIT_SUB:
      begin
        // Subtract is k + ~w + 1, so carry means no borrow
        if (op_i == `LIT_ADD)
          b = w_i;
        sum = {1'b0, k_i} + {1'b0, b} + {8'h00, op_i == `LIT_SUB};
        lo = {1'b0, k_i[3:0]} + {1'b0, b[3:0]} + {4'h0, op_i == `LIT_SUB};
        res_o = sum[7:0];
        flags_o[`FLAG_C] = sum[8];
        flags_o[`FLAG_DC] = lo[4];
        flags_o[`FLAG_OV] = (k_i[7] == b[7]) && (sum[7] != k_i[7]);
        mask_o = `FLAGS_ALL;
      end
      `LIT_AND:
      begin
        res_o = w_i & k_i;
        mask_o = `FLAGS_ZN;
      end
      `LIT_OR:
      begin
        res_o = w_i | k_i;
        mask_o = `FLAGS_ZN;
      end
      `LIT_XOR:
      begin
        res_o = w_i ^ k_i;
        mask_o = `FLAGS_ZN;
      end
      default:
      begin
        res_o = w_i;
        mask_o = 5'h00;
      end
    endcase
    flags_o[`FLAG_Z] = (res_o == 8'h00);
    flags_o[`FLAG_N] = res_o[7];
  end
endmodule
